// File: common/coevt_pkg.sv
package coevt_pkg;
  localparam int NUM_DIN_BITS = 64;
  localparam int NUM_AIN = 4;
  localparam int NUM_AOUT = 2;
  localparam int NUM_DOUT = 2;
  localparam int NUM_TPDO = 4;
  localparam int NUM_MASK = 2 * NUM_TPDO;
  localparam int ADC_BITS = 12;
  localparam int AVAL_W = 16;
  localparam int ADC_PAD = AVAL_W - ADC_BITS;
  localparam int PDO_W = 64;
  localparam int CNT_W = 32;
  localparam int STAT_W = 8;
  localparam int PDO_DIN = 0;
  localparam int PDO_AIN = 1;
  // Counter and status share the third PDO unless inputs spill over.
  localparam int PDO_CNT = (NUM_DIN_BITS < 65 && NUM_AIN < 5) ? 2 : 3;
  localparam logic [15:0] IDX_DOUT = 16'h6200;
  localparam logic [15:0] IDX_AIN = 16'h6401;
  localparam logic [15:0] IDX_AOUT = 16'h6411;
  localparam logic [15:0] IDX_EVT_EN = 16'h6423;
  localparam logic [15:0] IDX_UPPER = 16'h6424;
  localparam logic [15:0] IDX_LOWER = 16'h6425;
  localparam logic [15:0] IDX_DELTA = 16'h6426;
  localparam logic [15:0] IDX_MASK = 16'h6126;
  localparam logic [15:0] IDX_TPDO_COMM = 16'h1800;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_TTYPE = 8'h02;
  localparam logic [7:0] TT_SYNC_ACYC = 8'h00;
  localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
  localparam logic [7:0] TT_EVT_MFR = 8'hFE;
  localparam logic [7:0] TT_EVT_DEV = 8'hFF;
  localparam logic [7:0] TT_RST = 8'hFF;
  localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
  localparam logic [15:0] AVAL_RST = 16'h0000;
  localparam logic [7:0] DOUT_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

// File: hdl/coevt_chan.sv
`timescale 1ns/1ps
module coevt_chan (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Channel value and reference
  input wire logic [15:0] value,
  input wire logic [15:0] ref_value,
  // Parameters
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic [15:0] delta,
  // Results
  output logic armed,
  output logic trig
);
  typedef struct packed {
    logic over;
    logic under;
  } coevt_chan_st_t;

  coevt_chan_st_t q;
  coevt_chan_st_t d;
  logic up_on;
  logic lo_on;
  logic dl_on;
  logic over;
  logic under;
  logic [15:0] diff;

  assign up_on = (upper != '0);
  assign lo_on = (lower != '0);
  assign dl_on = (delta != '0);
  assign armed = up_on | lo_on | dl_on;
  // Both sides share the left-aligned unsigned format.
  assign over = up_on && (value > upper);
  assign under = lo_on && (value < lower);
  // Delta is unsigned, so the magnitude of the change is compared.
  assign diff = (value > ref_value) ? value - ref_value : ref_value - value;

  always_comb begin
    d = q;
    d.over = over;
    d.under = under;
  end

  // Limits fire on the crossing so a held excursion sends once.
  assign trig = (over && !q.over) || (under && !q.under) ||
                (dl_on && (diff > delta));

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

// File: hdl/coevt_pdotrig.sv
`timescale 1ns/1ps
module coevt_pdotrig (
  // Configuration
  input wire logic [7:0] ttype,
  input wire logic [63:0] mask,
  // Data
  input wire logic [63:0] cur,
  input wire logic [63:0] last,
  // Event sources
  input wire logic evt_allow,
  input wire logic limit_mode,
  input wire logic limit_trig,
  input wire logic sync_pulse,
  // Decision
  output logic send
);
  logic changed;
  logic changed_any;
  logic is_evt;

  // Only bits whose mask bits are set take part.
  assign changed = |((cur ^ last) & mask);
  // The acyclic synchronous type ignores the mask, so any change counts.
  assign changed_any = |(cur ^ last);
  assign is_evt = (ttype == coevt_pkg::TT_EVT_MFR) ||
                  (ttype == coevt_pkg::TT_EVT_DEV);

  always_comb begin
    send = 1'b0;
    if (is_evt) begin
      if (limit_mode) begin
        send = evt_allow && limit_trig;
      end else begin
        send = evt_allow && changed;
      end
    end else if (ttype == coevt_pkg::TT_SYNC_ACYC) begin
      send = sync_pulse && changed_any;
    end else if (ttype <= coevt_pkg::TT_SYNC_MAX) begin
      send = sync_pulse;
    end
  end
endmodule

// File: hdl/coevt_top.sv
`timescale 1ns/1ps
module coevt_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Process inputs
  input wire logic [63:0] din,
  input wire logic [47:0] ain_raw,
  input wire logic [7:0] cnt_status,
  input wire logic [31:0] cnt_value,
  input wire logic sync_pulse,
  // Process outputs
  output logic [15:0] dout,
  output logic [31:0] aout,
  // Object dictionary access
  input wire logic od_req,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_sub,
  input wire logic [31:0] od_wdata,
  output logic od_ack,
  output logic od_abort,
  output logic [31:0] od_rdata,
  // Transmit PDOs
  output logic [3:0] tpdo_req,
  output logic [255:0] tpdo_data
);
  localparam int NA = coevt_pkg::NUM_AIN;
  localparam int NP = coevt_pkg::NUM_TPDO;
  localparam int AW = coevt_pkg::AVAL_W;
  localparam int PW = coevt_pkg::PDO_W;

  typedef struct packed {
    logic [coevt_pkg::NUM_DOUT-1:0][7:0] dout;
    logic [coevt_pkg::NUM_AOUT-1:0][15:0] aout;
    logic evt_en;
    logic [NA-1:0][15:0] upper;
    logic [NA-1:0][15:0] lower;
    logic [NA-1:0][15:0] delta;
    logic [coevt_pkg::NUM_MASK-1:0][31:0] mask;
    logic [NP-1:0][7:0] ttype;
    logic [NP-1:0][63:0] last;
    logic [NP-1:0] req;
    logic ack;
    logic abort;
    logic [31:0] rdata;
  } coevt_top_st_t;

  coevt_top_st_t q;
  coevt_top_st_t d;
  logic [NA-1:0][15:0] ain;
  logic [NP-1:0][63:0] cur;
  logic [NA-1:0] ch_armed;
  logic [NA-1:0] ch_trig;
  logic [NP-1:0] send;
  logic limit_mode;

  // Converter codes are shifted to the top of the word.
  genvar gi;
  generate
    for (gi = 0; gi < NA; gi++) begin : g_ain
      assign ain[gi] = {ain_raw[gi*coevt_pkg::ADC_BITS +: coevt_pkg::ADC_BITS],
                        {coevt_pkg::ADC_PAD{1'b0}}};
      coevt_chan u_chan (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .value(ain[gi]),
        .ref_value(q.last[coevt_pkg::PDO_AIN][gi*AW +: AW]),
        .upper(q.upper[gi]),
        .lower(q.lower[gi]),
        .delta(q.delta[gi]),
        .armed(ch_armed[gi]),
        .trig(ch_trig[gi])
      );
    end
  endgenerate

  assign limit_mode = |ch_armed;

  // Current PDO images; channel 0 sits in bytes 0 and 1.
  always_comb begin
    cur = '0;
    cur[coevt_pkg::PDO_DIN] = din;
    cur[coevt_pkg::PDO_AIN] = ain;
    cur[coevt_pkg::PDO_CNT][coevt_pkg::STAT_W-1:0] = cnt_status;
    cur[coevt_pkg::PDO_CNT][coevt_pkg::STAT_W +: coevt_pkg::CNT_W] =
      cnt_value;
  end

  generate
    for (gi = 0; gi < NP; gi++) begin : g_pdo
      coevt_pdotrig u_trig (
        .ttype(q.ttype[gi]),
        .mask({q.mask[2*gi+1], q.mask[2*gi]}),
        .cur(cur[gi]),
        .last(q.last[gi]),
        .evt_allow((gi == coevt_pkg::PDO_AIN) ? q.evt_en : 1'b1),
        .limit_mode((gi == coevt_pkg::PDO_AIN) ? limit_mode : 1'b0),
        .limit_trig(|ch_trig),
        .sync_pulse(sync_pulse),
        .send(send[gi])
      );
    end
  endgenerate

  always_comb begin
    int e;
    int p;
    logic hit;
    e = int'(od_sub) - 1;
    p = int'(od_index) - int'(coevt_pkg::IDX_TPDO_COMM);
    hit = 1'b0;
    d = q;
    d.req = '0;
    d.ack = 1'b0;
    d.abort = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (send[i]) begin
        d.req[i] = 1'b1;
        // The sent image is the reference for change and delta checks.
        d.last[i] = cur[i];
      end
    end
    if (od_req) begin
      d.ack = 1'b1;
      d.rdata = coevt_pkg::RDATA_RST;
      case (od_index)
        coevt_pkg::IDX_DOUT: begin
          if (od_sub == coevt_pkg::SUB_COUNT) begin
            d.rdata = 32'(coevt_pkg::NUM_DOUT);
            d.abort = od_wr;
          end else if (e < coevt_pkg::NUM_DOUT) begin
            if (od_wr) begin
              d.dout[e] = od_wdata[7:0];
            end
            d.rdata = {24'h00_0000, d.dout[e]};
          end else begin
            d.abort = 1'b1;
          end
        end
        coevt_pkg::IDX_AIN: begin
          d.abort = od_wr;
          if (od_sub == coevt_pkg::SUB_COUNT) begin
            d.rdata = 32'(NA);
          end else if (e < NA) begin
            d.rdata = {16'h0000, ain[e]};
          end else begin
            d.abort = 1'b1;
          end
        end
        coevt_pkg::IDX_AOUT: begin
          if (od_sub == coevt_pkg::SUB_COUNT) begin
            d.rdata = 32'(coevt_pkg::NUM_AOUT);
            d.abort = od_wr;
          end else if (e < coevt_pkg::NUM_AOUT) begin
            if (od_wr) begin
              d.aout[e] = od_wdata[15:0];
            end
            d.rdata = {16'h0000, d.aout[e]};
          end else begin
            d.abort = 1'b1;
          end
        end
        coevt_pkg::IDX_EVT_EN: begin
          if (od_sub == coevt_pkg::SUB_COUNT) begin
            if (od_wr) begin
              d.evt_en = od_wdata[0];
            end
            d.rdata = {31'h0000_0000, d.evt_en};
          end else begin
            d.abort = 1'b1;
          end
        end
        coevt_pkg::IDX_UPPER,
        coevt_pkg::IDX_LOWER,
        coevt_pkg::IDX_DELTA: begin
          if (od_sub == coevt_pkg::SUB_COUNT) begin
            d.rdata = 32'(NA);
            d.abort = od_wr;
          end else if (e < NA) begin
            // Parameters may change at any time, enabled or not.
            if (od_index == coevt_pkg::IDX_UPPER) begin
              if (od_wr) begin
                d.upper[e] = od_wdata[15:0];
              end
              d.rdata = {16'h0000, d.upper[e]};
            end else if (od_index == coevt_pkg::IDX_LOWER) begin
              if (od_wr) begin
                d.lower[e] = od_wdata[15:0];
              end
              d.rdata = {16'h0000, d.lower[e]};
            end else begin
              if (od_wr) begin
                d.delta[e] = od_wdata[15:0];
              end
              d.rdata = {16'h0000, d.delta[e]};
            end
          end else begin
            d.abort = 1'b1;
          end
        end
        coevt_pkg::IDX_MASK: begin
          if (od_sub == coevt_pkg::SUB_COUNT) begin
            d.rdata = 32'(coevt_pkg::NUM_MASK);
            d.abort = od_wr;
          end else if (e < coevt_pkg::NUM_MASK) begin
            if (od_wr) begin
              // Value arrives already assembled from LSB-first bytes.
              d.mask[e] = od_wdata;
            end
            d.rdata = d.mask[e];
          end else begin
            d.abort = 1'b1;
          end
        end
        default: begin
          hit = (p >= 0) && (p < NP) && (od_sub == coevt_pkg::SUB_TTYPE);
          if (hit) begin
            if (od_wr) begin
              d.ttype[p] = od_wdata[7:0];
            end
            d.rdata = {24'h00_0000, d.ttype[p]};
          end else begin
            d.abort = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q.dout <= {coevt_pkg::NUM_DOUT{coevt_pkg::DOUT_RST}};
      q.aout <= {coevt_pkg::NUM_AOUT{coevt_pkg::AVAL_RST}};
      q.evt_en <= 1'b0;
      q.upper <= {NA{coevt_pkg::AVAL_RST}};
      q.lower <= {NA{coevt_pkg::AVAL_RST}};
      q.delta <= {NA{coevt_pkg::AVAL_RST}};
      q.mask <= {coevt_pkg::NUM_MASK{coevt_pkg::MASK_RST}};
      q.ttype <= {NP{coevt_pkg::TT_RST}};
      q.last <= '0;
      q.req <= '0;
      q.ack <= 1'b0;
      q.abort <= 1'b0;
      q.rdata <= coevt_pkg::RDATA_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dout = q.dout;
  assign aout = q.aout;
  assign od_ack = q.ack;
  assign od_abort = q.abort;
  assign od_rdata = q.rdata;
  assign tpdo_req = q.req;
  assign tpdo_data = q.last;
endmodule

// File: verification/coevt_sva.sv
`timescale 1ns/1ps
module coevt_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Process inputs
  input wire logic [63:0] din,
  input wire logic [47:0] ain_raw,
  input wire logic [7:0] cnt_status,
  input wire logic [31:0] cnt_value,
  // Object access
  input wire logic od_req,
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic od_ack,
  input wire logic od_abort,
  // Transmit PDOs
  input wire logic [3:0] tpdo_req,
  input wire logic [255:0] tpdo_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    od_req;
  endsequence
  sequence s_answer;
    od_ack;
  endsequence
  AST_ACK:
  assert property (s_take |=> s_answer) else $error("ack late");
  AST_RO_ABORT:
  assert property (od_req && od_wr && od_index == 16'h6401 |=> s_answer
    and od_abort) else $error("ro write taken");
  AST_CNT_STATUS:
  assert property (tpdo_req[2] |-> tpdo_data[135:128] == $past(cnt_status))
    else $error("status byte");
  AST_CNT_VALUE:
  assert property (tpdo_req[2] |-> tpdo_data[167:136] == $past(cnt_value))
    else $error("counter bytes");
  AST_AIN_LEFT:
  assert property (tpdo_req[1] |-> tpdo_data[79:64] ==
    {$past(ain_raw[11:0]), 4'h0}) else $error("ain align");
  AST_DIN_IMAGE:
  assert property (tpdo_req[0] |-> tpdo_data[63:0] == $past(din))
    else $error("din image");
  AST_AIN_PULSE:
  assert property (tpdo_req[1] && $stable(ain_raw) |=> !tpdo_req[1])
    else $error("ain resend");
  AST_AIN_HOLD:
  assert property (!tpdo_req[1] && !$past(rst) |->
    $stable(tpdo_data[127:64])) else $error("ain image moved");
endmodule

// File: verification/coevt_cmdr.sv
`timescale 1ns/1ps
module coevt_cmdr (
  // Clock
  input wire logic clk,
  // Request
  output logic od_req = 1'b0,
  output logic od_wr = 1'b0,
  output logic [15:0] od_index = 16'h0000,
  output logic [7:0] od_sub = 8'h00,
  output logic [31:0] od_wdata = 32'h0000_0000,
  // Answer
  input wire logic od_ack,
  input wire logic od_abort,
  input wire logic [31:0] od_rdata
);
  // A missing answer is reported as an abort.
  task automatic sdo(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] val,
      output logic abort, output logic [31:0] rdata);
    logic [7:0] f [8];
    f = '{wr ? 8'h22 : 8'h40, idx[7:0], idx[15:8], sub,
      val[7:0], val[15:8], val[23:16], val[31:24]};
    @(negedge clk);
    od_req = 1'b1;
    od_wr = (f[0] == 8'h22);
    od_index = {f[2], f[1]};
    od_sub = f[3];
    od_wdata = {f[7], f[6], f[5], f[4]};
    @(negedge clk);
    abort = od_abort | ~od_ack;
    rdata = od_rdata;
    od_req = 1'b0;
    od_wr = ~od_wr;
    od_index = ~od_index;
    od_sub = ~od_sub;
    od_wdata = ~od_wdata;
  endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst, ce, sync_pulse, od_req, od_wr, od_ack, od_abort;
  logic [63:0] din;
  logic [47:0] ain_raw;
  logic [7:0] cnt_status, od_sub;
  logic [31:0] cnt_value, aout, od_wdata, od_rdata;
  logic [15:0] dout, od_index;
  logic [3:0] tpdo_req;
  logic [255:0] tpdo_data;
  int mismatches = 0;
  int comparisons = 0;
  coevt_top coevt_top_inst (.*);
  coevt_cmdr coevt_cmdr_inst (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] val, input logic exp_ab);
    logic ab;
    logic [31:0] v;
    coevt_cmdr_inst.sdo(1'b1, idx, sub, val, ab, v);
    chk(64'(ab), 64'(exp_ab));
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] exp);
    logic ab;
    logic [31:0] v;
    coevt_cmdr_inst.sdo(1'b0, idx, sub, 32'h0000_0000, ab, v);
    chk(64'({ab, v}), 64'({1'b0, exp}));
  endtask
  task automatic sent(input int p, input logic exp);
    logic hit;
    hit = 1'b0;
    repeat (3) begin
      @(negedge clk);
      hit = hit | tpdo_req[p];
    end
    chk(64'(hit), 64'(exp));
  endtask
  task automatic sync_once(input logic exp);
    @(negedge clk);
    sync_pulse = 1'b1;
    @(negedge clk);
    sync_pulse = 1'b0;
    chk(64'(tpdo_req[1]), 64'(exp));
  endtask
  task automatic set_ain(input int ch, input logic [11:0] code);
    @(negedge clk);
    ain_raw[12*ch +: 12] = code;
  endtask
  task automatic t_regs();
    rd(16'h6423, 8'h00, 32'h0000_0000);
    rd(16'h6126, 8'h05, 32'hFFFF_FFFF);
    rd(16'h6426, 8'h01, 32'h0000_0000);
    for (int p = 1; p < 4; p++) begin
      rd(16'h1800 + 16'(p), 8'h02, 32'h0000_00FF);
    end
    wr(16'h6401, 8'h01, 32'h0000_1234, 1'b1);
    wr(16'h6000, 8'h01, 32'h0000_0001, 1'b1);
    wr(16'h6200, 8'h01, 32'h0000_00A5, 1'b0);
    chk(64'(dout), 64'h0000_0000_0000_00A5);
    wr(16'h6411, 8'h02, 32'h0000_ABC0, 1'b0);
    chk(64'(aout), 64'h0000_0000_ABC0_0000);
  endtask
  task automatic t_din();
    @(negedge clk);
    din = 64'h0000_0000_0000_0081;
    sent(0, 1'b1);
    chk(tpdo_data[63:0], 64'h0000_0000_0000_0081);
    sent(0, 1'b0);
    @(negedge clk);
    ce = 1'b0;
    din = 64'h0000_0000_0000_0003;
    sent(0, 1'b0);
    ce = 1'b1;
    sent(0, 1'b1);
    chk(tpdo_data[63:0], 64'h0000_0000_0000_0003);
  endtask
  task automatic t_mask();
    wr(16'h1802, 8'h02, 32'h0000_00FE, 1'b0);
    wr(16'h6126, 8'h05, 32'h0000_00FF, 1'b0);
    wr(16'h6126, 8'h06, 32'hFFFF_FF00, 1'b0);
    cnt_value = 32'h1234_5678;
    sent(2, 1'b0);
    cnt_status = 8'h41;
    sent(2, 1'b1);
    chk(64'(tpdo_data[167:128]), 64'({32'h1234_5678, 8'h41}));
  endtask
  task automatic t_analog();
    set_ain(0, 12'h100);
    sent(1, 1'b0);
    wr(16'h6423, 8'h00, 32'h0000_0001, 1'b0);
    sent(1, 1'b1);
    chk(64'(tpdo_data[79:64]), 64'h1000);
    wr(16'h6426, 8'h01, 32'h0000_0100, 1'b0);
    set_ain(0, 12'h110);
    sent(1, 1'b0);
    set_ain(0, 12'h111);
    sent(1, 1'b1);
    chk(64'(tpdo_data[79:64]), 64'h1110);
    set_ain(1, 12'h555);
    sent(1, 1'b0);
  endtask
  task automatic t_limits();
    wr(16'h6424, 8'h03, 32'h0000_8000, 1'b0);
    set_ain(2, 12'h800);
    sent(1, 1'b0);
    set_ain(2, 12'h801);
    sent(1, 1'b1);
    chk(64'(tpdo_data[111:96]), 64'h8010);
    set_ain(3, 12'h200);
    sent(1, 1'b0);
    wr(16'h6425, 8'h04, 32'h0000_1000, 1'b0);
    set_ain(3, 12'h0FF);
    sent(1, 1'b1);
    chk(64'(tpdo_data[127:112]), 64'h0FF0);
    wr(16'h6423, 8'h00, 32'h0000_0000, 1'b0);
    set_ain(0, 12'hF00);
    sent(1, 1'b0);
  endtask
  task automatic t_sync();
    wr(16'h1801, 8'h02, 32'h0000_0001, 1'b0);
    sent(1, 1'b0);
    sync_once(1'b1);
    chk(64'(tpdo_data[79:64]), 64'hF000);
    wr(16'h1801, 8'h02, 32'h0000_0000, 1'b0);
    sync_once(1'b0);
    wr(16'h6126, 8'h03, 32'h0000_0000, 1'b0);
    set_ain(0, 12'hABC);
    sync_once(1'b1);
    chk(64'(tpdo_data[79:64]), 64'hABC0);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sync_pulse = 1'b0;
    din = 64'h0000_0000_0000_0000;
    ain_raw = 48'h0000_0000_0000;
    cnt_status = 8'h00;
    cnt_value = 32'h0000_0000;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_din();
    t_mask();
    t_analog();
    t_limits();
    t_sync();
    print_verdict();
  end
  initial begin
    #100us;
    mismatches++;
    print_verdict();
  end
endmodule
bind coevt_top coevt_sva coevt_sva_inst (.*);
